// ### src/rsc_defs.vh
// Constants for the reset source controller
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_ADDR_SRC 12'h000
`define RSC_ADDR_CTRL 12'h004
`define RSC_ADDR_IRQ_STAT 12'h008
`define RSC_ADDR_IRQ_MASK 12'h00C
`define RSC_BIT_PIN 0
`define RSC_BIT_VMON 1
`define RSC_BIT_CLK 2
`define RSC_BIT_CMP 5
`define RSC_BIT_WDT 3
`define RSC_BIT_FLASH 6
`define RSC_BIT_SOFT 4
`define RSC_BIT_MON_EN 0
`define RSC_NSRC 7
`define RSC_HOLD_CYCLES 8'h08
`define RSC_CLK_WIN_NS 100
`define RSC_CLK_PERIOD_NS 5
`define RSC_ZERO32 32'h00000000
`endif

// ### src/rsc_sync.v
// Two-flop synchroniser for one level input
`timescale 1ns/1ps
module rsc_sync #(
   parameter RESET_VAL = 1'b0
) (
   input wire pclk,
   input wire presetn,
   input wire din,
   output reg dout
);
   reg stage1;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // rsc_sync

// ### src/rsc_reset_source_controller.v
// Reset source controller: combines reset causes, records the last cause, APB registers
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_reset_source_controller #(
   parameter HOLD_CYCLES = `RSC_HOLD_CYCLES,
   parameter CLK_WIN_NS = `RSC_CLK_WIN_NS
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire ext_reset_n,
   input wire sys_clk_mon,
   input wire comparator_out,
   input wire supply_monitor_low,
   input wire watchdog_expired,
   input wire flash_write_above,
   input wire flash_read_above,
   input wire fetch_above,
   input wire flash_secure_block,
   output reg sys_reset_n,
   output reg supply_monitor_enable,
   output reg irq
);
   localparam WIN_CYC = (CLK_WIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS;
   localparam [7:0] WIN_CYC8 = WIN_CYC[7:0];
   localparam [7:0] HOLD8 = HOLD_CYCLES[7:0];
   localparam ST_RUN = 1'b0;
   localparam ST_RESET = 1'b1;

   wire ext_n_s;
   wire clk_mon_s;
   wire cmp_s;
   wire vmon_s;
   wire wdt_s;
   wire fwa_s;
   wire fra_s;
   wire fet_s;
   wire fsb_s;

   // Reset values of the synchronisers are chosen so no cause is seen during reset
   // Pin and comparator idle high, so their stages reset high
   rsc_sync #(.RESET_VAL(1'b1)) u_ext (
      .pclk(pclk),
      .presetn(presetn),
      .din(ext_reset_n),
      .dout(ext_n_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .din(sys_clk_mon),
      .dout(clk_mon_s)
   );
   rsc_sync #(.RESET_VAL(1'b1)) u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .din(comparator_out),
      .dout(cmp_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_vmon (
      .pclk(pclk),
      .presetn(presetn),
      .din(supply_monitor_low),
      .dout(vmon_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_wdt (
      .pclk(pclk),
      .presetn(presetn),
      .din(watchdog_expired),
      .dout(wdt_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_fwa (
      .pclk(pclk),
      .presetn(presetn),
      .din(flash_write_above),
      .dout(fwa_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_fra (
      .pclk(pclk),
      .presetn(presetn),
      .din(flash_read_above),
      .dout(fra_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_fet (
      .pclk(pclk),
      .presetn(presetn),
      .din(fetch_above),
      .dout(fet_s)
   );
   rsc_sync #(.RESET_VAL(1'b0)) u_fsb (
      .pclk(pclk),
      .presetn(presetn),
      .din(flash_secure_block),
      .dout(fsb_s)
   );

   reg state;
   reg [7:0] hold_cnt;
   reg [7:0] win_cnt;
   reg clk_mon_d;
   reg clk_loss_enable;
   reg cmp_enable;
   reg vmon_src_enable;
   reg soft_req;
   reg [6:0] cause_flags;
   reg [6:0] latched_cause;
   reg [6:0] irq_stat;
   reg [6:0] irq_mask;
   reg [31:0] next_prdata;
   reg cmp_active;

   wire apb_setup = psel && !penable;
   wire apb_acc = psel && penable && pready;
   wire apb_wr = apb_acc && pwrite;
   wire apb_rd = apb_acc && !pwrite;
   wire hit_src = (paddr == `RSC_ADDR_SRC);
   wire hit_ctrl = (paddr == `RSC_ADDR_CTRL);
   wire hit_stat = (paddr == `RSC_ADDR_IRQ_STAT);
   wire hit_mask = (paddr == `RSC_ADDR_IRQ_MASK);
   wire hit_any = hit_src || hit_ctrl || hit_stat || hit_mask;

   wire clk_edge = clk_mon_s ^ clk_mon_d;
   wire clk_lost = clk_loss_enable && (win_cnt == WIN_CYC8);
   wire flash_err = fwa_s || fra_s || fet_s || fsb_s;
   wire soft_wr = apb_wr && hit_src && pwdata[`RSC_BIT_SOFT];

   // Causes in priority order; only one is recorded per reset
   reg [6:0] now_cause;
   always @* begin
      now_cause = 7'h00;
      if (!ext_n_s) begin
         now_cause[`RSC_BIT_PIN] = 1'b1;
      end else if (vmon_src_enable && vmon_s) begin
         now_cause[`RSC_BIT_VMON] = 1'b1;
      end else if (clk_lost) begin
         now_cause[`RSC_BIT_CLK] = 1'b1;
      end else if (cmp_enable && !cmp_s) begin
         now_cause[`RSC_BIT_CMP] = 1'b1;
      end else if (wdt_s) begin
         now_cause[`RSC_BIT_WDT] = 1'b1;
      end else if (flash_err) begin
         now_cause[`RSC_BIT_FLASH] = 1'b1;
      end else if (soft_req) begin
         now_cause[`RSC_BIT_SOFT] = 1'b1;
      end
   end
   wire any_cause = |now_cause;

   // Clock-loss one-shot, restarted by every edge of the monitored clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_mon_d <= 1'b0;
         win_cnt <= 8'h00;
      end else begin
         clk_mon_d <= clk_mon_s;
         if (clk_edge || !clk_loss_enable || state == ST_RESET) begin
            win_cnt <= 8'h00;
         end else if (win_cnt != WIN_CYC8) begin
            win_cnt <= win_cnt + 8'h01;
         end
      end
   end

   // Reset sequencer: held while the pin or comparator cause stays, then a minimum stretch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_RESET;
         hold_cnt <= HOLD8;
         latched_cause <= 7'h00;
         sys_reset_n <= 1'b0;
      end else begin
         case (state)
            ST_RUN: begin
               sys_reset_n <= 1'b1;
               if (any_cause) begin
                  state <= ST_RESET;
                  latched_cause <= now_cause;
                  hold_cnt <= HOLD8;
                  sys_reset_n <= 1'b0;
               end
            end
            ST_RESET: begin
               sys_reset_n <= 1'b0;
               if (!ext_n_s || (cmp_active && !cmp_s)) begin
                  hold_cnt <= HOLD8;
               end else if (hold_cnt != 8'h00) begin
                  hold_cnt <= hold_cnt - 8'h01;
               end else begin
                  state <= ST_RUN;
                  sys_reset_n <= 1'b1;
               end
            end
            default: begin
               state <= ST_RESET;
            end
         endcase
      end
   end

   // Flags are committed on exit, so only the latest cause reads 1
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_flags <= 7'h00;
         cmp_active <= 1'b0;
      end else begin
         if (state == ST_RUN && any_cause) begin
            cmp_active <= now_cause[`RSC_BIT_CMP];
         end
         if (state == ST_RESET && !(!ext_n_s || (cmp_active && !cmp_s)) && hold_cnt == 8'h00) begin
            cause_flags <= latched_cause;
         end
      end
   end

   // Enables; a system reset clears the source enables, the supply monitor bit survives
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_loss_enable <= 1'b0;
         cmp_enable <= 1'b0;
         vmon_src_enable <= 1'b0;
         soft_req <= 1'b0;
         supply_monitor_enable <= 1'b0;
      end else if (state == ST_RESET) begin
         clk_loss_enable <= 1'b0;
         cmp_enable <= 1'b0;
         vmon_src_enable <= 1'b0;
         soft_req <= 1'b0;
      end else begin
         soft_req <= soft_wr;
         if (apb_wr && hit_src) begin
            clk_loss_enable <= pwdata[`RSC_BIT_CLK];
            cmp_enable <= pwdata[`RSC_BIT_CMP];
            vmon_src_enable <= pwdata[`RSC_BIT_VMON];
         end
         if (apb_wr && hit_ctrl) begin
            supply_monitor_enable <= pwdata[`RSC_BIT_MON_EN];
         end
      end
   end

   // Interrupt status: set on reset exit, cleared by a read; a set wins over the clear
   wire [6:0] set_evt = (state == ST_RESET && hold_cnt == 8'h00 && ext_n_s && !(cmp_active && !cmp_s))
                        ? latched_cause : 7'h00;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 7'h00;
         irq_mask <= 7'h00;
         irq <= 1'b0;
      end else begin
         if (apb_rd && hit_stat) begin
            irq_stat <= set_evt;
         end else begin
            irq_stat <= irq_stat | set_evt;
         end
         if (apb_wr && hit_mask) begin
            irq_mask <= pwdata[6:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Source register read: flag bits, with the live vmon_src_enable ORed into the VMON bit
   always @* begin
      next_prdata = `RSC_ZERO32;
      if (hit_src) begin
         next_prdata[6:0] = cause_flags;
         next_prdata[`RSC_BIT_VMON] = vmon_src_enable | cause_flags[`RSC_BIT_VMON];
      end else if (hit_ctrl) begin
         next_prdata[`RSC_BIT_MON_EN] = supply_monitor_enable;
      end else if (hit_stat) begin
         next_prdata[6:0] = irq_stat;
      end else if (hit_mask) begin
         next_prdata[6:0] = irq_mask;
      end
   end

   // APB slave: no wait states, read data registered during setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `RSC_ZERO32;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (apb_setup) begin
            pready <= 1'b1;
            pslverr <= !hit_any;
            prdata <= pwrite ? `RSC_ZERO32 : next_prdata;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end
   // The external reset pin is input only here; internal causes never drive it
endmodule // rsc_reset_source_controller

// ### sim/rsc_reset_source_controller_props.sv
// Checker for the reset source controller ports
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_reset_source_controller_props #(
   parameter HOLD_CYCLES = 8,
   parameter CLK_WIN_NS = 100
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire ext_reset_n,
   input wire watchdog_expired,
   input wire flash_write_above,
   input wire flash_read_above,
   input wire fetch_above,
   input wire flash_secure_block,
   input wire sys_reset_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire flash_bad = flash_write_above | flash_read_above | fetch_above | flash_secure_block;
   wire src_rd = pready & !pwrite & !pslverr & (paddr == `RSC_ADDR_SRC);
   wire soft_wr = psel & penable & pready & pwrite & (paddr == `RSC_ADDR_SRC) & pwdata[4];
   property p_pin; !ext_reset_n [*3] |-> ##[0:2] !sys_reset_n; endproperty
   a_pin: assert property (p_pin) else $error("pin low gave no reset");
   property p_pin_hold; $rose(sys_reset_n) |-> $past(ext_reset_n, 2); endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("reset left while pin low");
   property p_wdt; watchdog_expired [*3] |-> ##[0:2] !sys_reset_n; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog gave no reset");
   property p_flash; flash_bad [*3] |-> ##[0:2] !sys_reset_n; endproperty
   a_flash: assert property (p_flash) else $error("flash error gave no reset");
   property p_soft; soft_wr && sys_reset_n |-> ##[1:4] !sys_reset_n; endproperty
   a_soft: assert property (p_soft) else $error("soft reset write ignored");
   property p_one; src_rd |-> $countones(prdata[6:0] & 7'h7D) <= 1; endproperty
   a_one: assert property (p_one) else $error("more than one cause flag");
   property p_refuse; pslverr |-> pready && prdata == 32'h0; endproperty
   a_refuse: assert property (p_refuse) else $error("bad refused access");
   property p_pulse; psel && !penable |=> pready ##1 !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready not a one cycle answer");
   property p_stretch; $fell(sys_reset_n) |=> !sys_reset_n [*2]; endproperty
   a_stretch: assert property (p_stretch) else $error("reset pulse too short");
   c_soft: cover property (soft_wr);
   c_refuse: cover property (pslverr);
   c_leave: cover property ($rose(sys_reset_n));
endmodule // rsc_reset_source_controller_props
bind rsc_reset_source_controller rsc_reset_source_controller_props #(
   .HOLD_CYCLES(HOLD_CYCLES), .CLK_WIN_NS(CLK_WIN_NS)) i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_reset_n(ext_reset_n), .watchdog_expired(watchdog_expired), .flash_write_above(flash_write_above),
   .flash_read_above(flash_read_above), .fetch_above(fetch_above), .flash_secure_block(flash_secure_block),
   .sys_reset_n(sys_reset_n));

// ### sim/rsc_far_model.sv
// Far side model: reset pin, reset requesters and monitored clock
`timescale 1ns/1ps
module rsc_far_model (
   input wire pclk,
   input wire [3:0] cmd,
   output wire ext_reset_n,
   output reg sys_clk_mon,
   output wire supply_monitor_low,
   output wire comparator_out,
   output wire watchdog_expired,
   output wire flash_write_above,
   output wire flash_read_above,
   output wire fetch_above,
   output wire flash_secure_block
);
   // Pin rests at its pull-up level
   assign ext_reset_n = (cmd != 4'h1);
   assign supply_monitor_low = (cmd == 4'h2);
   // Comparator is settled high unless told to drop
   assign comparator_out = (cmd != 4'h4);
   assign watchdog_expired = (cmd == 4'h5);
   assign flash_write_above = (cmd == 4'h6);
   assign flash_read_above = (cmd == 4'h7);
   assign fetch_above = (cmd == 4'h8);
   assign flash_secure_block = (cmd == 4'h9);
   initial sys_clk_mon = 1'h0;
   // Stalls on request so the detector window runs out
   always @(posedge pclk) begin
      if (cmd != 4'h3) begin
         sys_clk_mon <= ~sys_clk_mon;
      end
   end
endmodule // rsc_far_model

// ### sim/test_rsc_reset_source_controller.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`include "rsc_defs.vh"
module test_rsc_reset_source_controller;
   reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0, rd, m;
   reg [3:0] cmd = 4'h0;
   reg err;
   integer errors = 0, tests_run = 0, i, k;
   wire [31:0] prdata;
   wire pready, pslverr, ext_n, clk_mon, sup_low, cmp, wdt, fw, fr, fe, fs, sys_reset_n, mon_en, irq;
   always #2.5 pclk = ~pclk;
   rsc_reset_source_controller #(.HOLD_CYCLES(2)) i_rsc_reset_source_controller (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_n), .sys_clk_mon(clk_mon),
      .comparator_out(cmp), .supply_monitor_low(sup_low), .watchdog_expired(wdt), .flash_write_above(fw),
      .flash_read_above(fr), .fetch_above(fe), .flash_secure_block(fs), .sys_reset_n(sys_reset_n),
      .supply_monitor_enable(mon_en), .irq(irq));
   rsc_far_model i_rsc_far_model (.pclk(pclk), .cmd(cmd), .ext_reset_n(ext_n), .sys_clk_mon(clk_mon),
      .supply_monitor_low(sup_low), .comparator_out(cmp), .watchdog_expired(wdt), .flash_write_above(fw),
      .flash_read_above(fr), .fetch_above(fe), .flash_secure_block(fs));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, errors);
         if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         @(posedge pclk);
         while (pready !== 1'h1) begin
            @(posedge pclk);
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   task wait_rst(input lvl);
      integer n;
      begin
         n = 0;
         while (sys_reset_n !== lvl && n < 200) begin
            @(posedge pclk);
            n = n + 1;
         end
         check(sys_reset_n, lvl);
      end
   endtask
   // Raise one cause until the reset is seen, then read which flag it left
   task cause(input [3:0] c, input [31:0] exp);
      begin
         cmd <= c;
         wait_rst(1'h0);
         cmd <= 4'h0;
         wait_rst(1'h1);
         apb(1'h0, `RSC_ADDR_SRC, 32'h0);
         check(rd & 32'h7D, exp);
         $display("test %0d done", tests_run);
      end
   endtask
   initial begin
      k = $urandom(32);
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      wait_rst(1'h1);
      apb(1'h0, `RSC_ADDR_SRC, 32'h0);
      check(rd, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      check({rd[30:0], err}, 32'h1);
      apb(1'h1, `RSC_ADDR_SRC, 32'h10);
      cause(4'h0, 32'h10);
      cause(4'h5, 32'h08);
      cause(4'h1, 32'h01);
      k = $urandom % 4;
      for (i = 0; i < 4; i = i + 1) cause(4'h6 + ((k[3:0] + i[3:0]) & 4'h3), 32'h40);
      apb(1'h1, `RSC_ADDR_SRC, 32'h04);
      cause(4'h3, 32'h04);
      apb(1'h1, `RSC_ADDR_SRC, 32'h24);
      apb(1'h1, `RSC_ADDR_SRC, 32'h0);
      // Both sources now off: a stall or a low comparator must pass unnoticed
      for (i = 3; i < 5; i = i + 1) begin
         cmd <= i[3:0];
         repeat (40) @(posedge pclk);
         check(sys_reset_n, 1'h1);
         cmd <= 4'h0;
         @(posedge pclk);
      end
      apb(1'h1, `RSC_ADDR_SRC, 32'h20);
      cause(4'h4, 32'h20);
      apb(1'h1, `RSC_ADDR_CTRL, 32'h1);
      check(mon_en, 1'h1);
      apb(1'h1, `RSC_ADDR_SRC, 32'h02);
      cause(4'h2, 32'h0);
      check(rd, 32'h02);
      m = $urandom & 32'h7F;
      apb(1'h1, `RSC_ADDR_IRQ_MASK, m);
      apb(1'h0, `RSC_ADDR_IRQ_MASK, 32'h0);
      check(rd, m);
      check({31'h0, irq}, {31'h0, |m[6:0]});
      apb(1'h0, `RSC_ADDR_IRQ_STAT, 32'h0);
      check(rd, 32'h7F);
      apb(1'h0, `RSC_ADDR_IRQ_STAT, 32'h0);
      check({rd[30:0], irq}, 32'h0);
      wrap_up;
   end
   initial begin
      #50000;
      errors = errors + 1;
      wrap_up;
   end
endmodule // test_rsc_reset_source_controller
